// ### src/asp_pkg.sv
// constants, types and decode functions shared by both ends of the
// serial audio port; assumes a single 40 MHz system clock on each end.
// Operation
// - port is bit clock, word clock, data
// - speed mode follows sample rate band
// - master two-channel bit clock is 64 Fs
// - master TDM bit clock is 256 Fs
// - TDM sync 128 high; slave accepts 1..244
// - master duty 50 or 33 percent
// - slave two-channel ratio free, supported recommended
// - slave TDM ratio free, supported recommended
// - word clock stable around bit clock rise
// - data valid across rise, captured there
package asp_pkg;

   typedef enum logic [1:0] {
      ASP_FMT_I2S = 2'b00,
      ASP_FMT_LJ = 2'b01,
      ASP_FMT_TDM = 2'b10
   } asp_fmt_e;

   typedef enum logic [1:0] {
      ASP_SPD_SINGLE = 2'b00,
      ASP_SPD_DOUBLE = 2'b01,
      ASP_SPD_QUAD = 2'b10
   } asp_speed_e;

   // sample rate band edges per speed mode, in kHz
   localparam int unsigned ASP_FS_SINGLE_MIN_KHZ = 2;
   localparam int unsigned ASP_FS_DOUBLE_MIN_KHZ = 54;
   localparam int unsigned ASP_FS_QUAD_MIN_KHZ = 108;
   localparam int unsigned ASP_FS_QUAD_MAX_KHZ = 216;

   localparam int unsigned ASP_SAMPLE_W = 24;
   localparam int unsigned ASP_FIFO_DEPTH = 8;

   // frame geometry in bit clocks
   localparam logic [7:0] ASP_FRAME_LAST_2CH = 8'h3f;
   localparam logic [7:0] ASP_FRAME_LAST_TDM = 8'hff;
   localparam logic [7:0] ASP_HALF_2CH = 8'h20;
   localparam logic [7:0] ASP_FS_HIGH_TDM = 8'h80;
   localparam logic [5:0] ASP_SLOT_LAST_2CH = 6'h1f;
   localparam logic [5:0] ASP_SLOT_LAST_TDM = 6'h3f;
   localparam logic [5:0] ASP_MSB_BIT = 6'h00;
   localparam logic [5:0] ASP_LSB_BIT = 6'h17;
   localparam logic [5:0] ASP_BITS_PER_SAMPLE = 6'h18;
   localparam logic [7:0] ASP_FS_WIDTH_MIN = 8'h01;
   localparam logic [7:0] ASP_FS_WIDTH_MAX = 8'hf4;

   // device master bit clock period in system clocks per speed mode
   localparam logic [7:0] ASP_BCLK_CYC_2CH_SS = 8'h18;
   localparam logic [7:0] ASP_BCLK_CYC_2CH_DS = 8'h10;
   localparam logic [7:0] ASP_BCLK_CYC_2CH_QS = 8'h0c;
   localparam logic [7:0] ASP_BCLK_CYC_TDM = 8'h0c;

   // host master bit clock, derived from time and system clock rate
   localparam int unsigned ASP_CLK_PERIOD_NS = 25;
   localparam int unsigned ASP_HOST_BCLK_NS = 400;
   localparam logic [7:0] ASP_HOST_BCLK_CYC =
      8'(ASP_HOST_BCLK_NS / ASP_CLK_PERIOD_NS);
   localparam logic [7:0] ASP_HOST_BCLK_HIGH = ASP_HOST_BCLK_CYC >> 1;

   // bit clock period; faster modes shorten the two-channel frame time, TDM keeps one period
   function automatic logic [7:0] asp_bclk_period(asp_fmt_e fmt,
                                                  asp_speed_e spd);
      logic [7:0] p;
      p = ASP_BCLK_CYC_2CH_SS;
      if (fmt == ASP_FMT_TDM)
      begin
         p = ASP_BCLK_CYC_TDM;
      end
      else if (spd == ASP_SPD_DOUBLE)
      begin
         p = ASP_BCLK_CYC_2CH_DS;
      end
      else if (spd == ASP_SPD_QUAD)
      begin
         p = ASP_BCLK_CYC_2CH_QS;
      end
      return p;
   endfunction

   // high time: a third of the period or half of it
   function automatic logic [7:0] asp_bclk_high(logic [7:0] period,
                                                logic duty_third);
      logic [7:0] h;
      h = duty_third ? period / 8'h03 : period >> 1;
      return h;
   endfunction

   // word clock or frame sync level for a frame position
   function automatic logic asp_ws_level(asp_fmt_e fmt, logic [7:0] pos);
      logic lvl;
      case (fmt)
         ASP_FMT_TDM: lvl = pos < ASP_FS_HIGH_TDM;
         ASP_FMT_LJ: lvl = pos < ASP_HALF_2CH;
         default: lvl = pos >= ASP_HALF_2CH;
      endcase
      return lvl;
   endfunction

   function automatic logic [7:0] asp_frame_last(asp_fmt_e fmt);
      return (fmt == ASP_FMT_TDM) ? ASP_FRAME_LAST_TDM : ASP_FRAME_LAST_2CH;
   endfunction

endpackage

// ### src/asp_if.sv
// link between the converter end and the receiver end; resolves the
// two-way bit clock and word clock from the drive enables.
// assumes at most one end enables each pin at a time.
`timescale 1ns/100ps
interface asp_if;
   logic bclk_dev;
   logic bclk_dev_oe_n;
   logic bclk_host;
   logic bclk_host_oe_n;
   logic ws_dev;
   logic ws_dev_oe_n;
   logic ws_host;
   logic ws_host_oe_n;
   logic serial_data_out;
   logic link_bclk;
   logic word_select_clock;

   // undriven pins read low, as if pulled down
   assign link_bclk = !bclk_dev_oe_n ? bclk_dev :
                      (!bclk_host_oe_n ? bclk_host : 1'b0);
   assign word_select_clock = !ws_dev_oe_n ? ws_dev :
                              (!ws_host_oe_n ? ws_host : 1'b0);

   modport dev (
      output bclk_dev, bclk_dev_oe_n, ws_dev, ws_dev_oe_n, serial_data_out,
      input link_bclk, word_select_clock
   );
   modport host (
      output bclk_host, bclk_host_oe_n, ws_host, ws_host_oe_n,
      input link_bclk, word_select_clock, serial_data_out
   );
endinterface

// ### src/asp_dev.sv
// converter end of the serial audio port: sample fifo plus serialiser,
// as bit clock master or slave. assumes config inputs change only while
// the link is idle and samples arrive in channel order.
`timescale 1ns/100ps
module asp_fifo
   import asp_pkg::*;
#(
   parameter int unsigned WIDTH = ASP_SAMPLE_W,
   parameter int unsigned DEPTH = ASP_FIFO_DEPTH
)(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int unsigned AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] PTR_ONE = AW'(1);
   localparam logic [AW:0] CNT_ONE = (AW+1)'(1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic rdy_q, rdy_d;
   logic push, pop;

   assign in_ready_o = rdy_q;
   assign out_valid_o = cnt_q != '0;
   assign out_data_o = mem_q[rd_q];
   assign push = in_valid_i & rdy_q;
   assign pop = out_valid_o & out_ready_i;

   // pointers wrap naturally; depth must be a power of two
   always_comb
   begin
      wr_d = push ? wr_q + PTR_ONE : wr_q;
      rd_d = pop ? rd_q + PTR_ONE : rd_q;
      cnt_d = cnt_q;
      if (push && !pop)
      begin
         cnt_d = cnt_q + CNT_ONE;
      end
      else if (pop && !push)
      begin
         cnt_d = cnt_q - CNT_ONE;
      end
      rdy_d = cnt_d != FULL; // ready held in a flop, not decoded
   end

   // write port, one entry per generated slot
   for (genvar i = 0; i < DEPTH; i++)
   begin : g_mem
      assign mem_d[i] = (push && wr_q == AW'(i)) ? in_data_i : mem_q[i];
      always_ff @(posedge clk_i or posedge rst_i)
      begin
         if (rst_i)
         begin
            mem_q[i] <= '0;
         end
         else if (ce_i)
         begin
            mem_q[i] <= mem_d[i];
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         rdy_q <= 1'b0;
      end
      else if (ce_i)
      begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
         rdy_q <= rdy_d;
      end
   end
endmodule

module asp_dev
   import asp_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic master_i,
   input wire asp_fmt_e fmt_i,
   input wire asp_speed_e speed_i,
   input wire logic divider_duty_select_i,
   input wire logic sample_valid_i,
   input wire logic [ASP_SAMPLE_W-1:0] sample_data_i,
   output logic sample_ready_o,
   output logic underrun_o,
   asp_if.dev link
);
   logic bclk_s1_q, bclk_s2_q, bclk_s3_q;
   logic ws_s1_q, ws_s2_q, ws_prev_q, ws_prev_d;
   logic [7:0] div_q, div_d, pos_q, pos_d;
   logic bclk_q, bclk_d, ws_q, ws_d, sdata_q, sdata_d;
   logic oe_n_q, under_q, under_d;
   logic [ASP_SAMPLE_W-1:0] shreg_q, shreg_d;
   logic fifo_valid, fifo_pop;
   logic [ASP_SAMPLE_W-1:0] fifo_data, word;
   logic [7:0] period, high, pos_next, dpos;
   logic [5:0] bitn;
   logic tdm, fall, rise_s, left;

   asp_fifo #(
      .WIDTH(ASP_SAMPLE_W),
      .DEPTH(ASP_FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .in_valid_i(sample_valid_i),
      .in_data_i(sample_data_i),
      .in_ready_o(sample_ready_o),
      .out_valid_o(fifo_valid),
      .out_data_o(fifo_data),
      .out_ready_i(fifo_pop)
   );

   // three pins only: bit clock, word clock, data
   assign link.bclk_dev = bclk_q;
   assign link.bclk_dev_oe_n = oe_n_q;
   assign link.ws_dev = ws_q;
   assign link.ws_dev_oe_n = oe_n_q;
   assign link.serial_data_out = sdata_q;
   assign underrun_o = under_q;

   // pins from the other clock domain, two flops before any use
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         bclk_s1_q <= 1'b0;
         bclk_s2_q <= 1'b0;
         bclk_s3_q <= 1'b0;
         ws_s1_q <= 1'b0;
         ws_s2_q <= 1'b0;
      end
      else if (ce_i)
      begin
         bclk_s1_q <= link.link_bclk;
         bclk_s2_q <= bclk_s1_q;
         bclk_s3_q <= bclk_s2_q;
         ws_s1_q <= link.word_select_clock;
         ws_s2_q <= ws_s1_q;
      end
   end

   // serialiser: word clock and data change on a bit clock fall so that they are
   // settled around the next rise; slave mode adds sync latency, so the
   // slave bit clock must stay slow against the system clock
   always_comb
   begin
      tdm = fmt_i == ASP_FMT_TDM;
      // speed sets the two-channel period, TDM has one fixed period; 64 or 256 bits a frame
      period = asp_bclk_period(fmt_i, speed_i);
      high = asp_bclk_high(period, divider_duty_select_i);
      div_d = '0;
      bclk_d = 1'b0;
      if (master_i)
      begin
         div_d = (div_q == period - 8'h01) ? 8'h00 : div_q + 8'h01;
         // level from the present count, so the first pulse after
         // reset is as long as every later one
         bclk_d = div_q < high;
      end
      fall = master_i ? (div_q == high) : (~bclk_s2_q & bclk_s3_q);
      rise_s = ~master_i & bclk_s2_q & ~bclk_s3_q;
      // frame is 64 bits two-channel, 256 TDM
      pos_next = (pos_q == asp_frame_last(fmt_i)) ? 8'h00 : pos_q + 8'h01;
      dpos = (fmt_i == ASP_FMT_I2S) ? pos_next - 8'h01 : pos_next;
      bitn = tdm ? dpos[5:0] : {1'b0, dpos[4:0]};
      word = fifo_valid ? fifo_data : '0;
      left = (fmt_i == ASP_FMT_I2S) ? ~ws_s2_q : ws_s2_q;
      pos_d = pos_q;
      ws_d = ws_q;
      sdata_d = sdata_q;
      shreg_d = shreg_q;
      ws_prev_d = ws_prev_q;
      fifo_pop = 1'b0;
      under_d = 1'b0;
      if (fall)
      begin
         pos_d = pos_next;
         ws_d = asp_ws_level(fmt_i, pos_next);
         sdata_d = 1'b0;
         // slot start loads the next sample, MSB first
         if (bitn == ASP_MSB_BIT)
         begin
            fifo_pop = fifo_valid;
            under_d = ~fifo_valid; // empty fifo sends silence
            sdata_d = word[ASP_SAMPLE_W-1];
            shreg_d = word << 1;
         end
         else if (bitn <= ASP_LSB_BIT)
         begin
            sdata_d = shreg_q[ASP_SAMPLE_W-1];
            shreg_d = shreg_q << 1;
         end
      end
      // slave: realign to whatever ratio the source uses, sync width
      // free since only the edge counts
      if (rise_s)
      begin
         ws_prev_d = ws_s2_q;
         if (tdm && ws_s2_q && !ws_prev_q)
         begin
            pos_d = 8'h00;
         end
         else if (!tdm && ws_s2_q != ws_prev_q)
         begin
            pos_d = left ? 8'h00 : ASP_HALF_2CH;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         div_q <= '0;
         pos_q <= ASP_FRAME_LAST_TDM;
         bclk_q <= 1'b0;
         ws_q <= 1'b0;
         sdata_q <= 1'b0;
         shreg_q <= '0;
         ws_prev_q <= 1'b0;
         oe_n_q <= 1'b1;
         under_q <= 1'b0;
      end
      else if (ce_i)
      begin
         div_q <= div_d;
         pos_q <= pos_d;
         bclk_q <= bclk_d;
         ws_q <= ws_d;
         sdata_q <= sdata_d;
         shreg_q <= shreg_d;
         ws_prev_q <= ws_prev_d;
         oe_n_q <= ~master_i; // drive clocks only as master
         under_q <= under_d;
      end
   end
endmodule

// ### src/asp_host.sv
// receiver end of the serial audio port (dsp side): optional bit clock
// master and a deserialiser capturing data on bit clock rises.
// assumes the bit clock period is at least 8 system clocks.
`timescale 1ns/100ps
module asp_host
   import asp_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic master_i,
   input wire asp_fmt_e fmt_i,
   output logic [ASP_SAMPLE_W-1:0] sample_o,
   output logic [1:0] chan_o,
   output logic sample_valid_o,
   asp_if.host link
);
   logic bclk_s1_q, bclk_s2_q, bclk_s3_q;
   logic ws_s1_q, ws_s2_q, sd_s1_q, sd_s2_q;
   logic [7:0] div_q, div_d, pos_q, pos_d;
   logic bclk_q, bclk_d, ws_q, ws_d, oe_n_q;
   logic ws_prev_q, ws_prev_d;
   logic [5:0] bit_q, bit_d, didx;
   logic [1:0] slot_q, slot_d, chan_d;
   logic [ASP_SAMPLE_W-1:0] shreg_q, shreg_d, sample_d;
   logic valid_d, tdm, rise, left, start;

   assign link.bclk_host = bclk_q;
   assign link.bclk_host_oe_n = oe_n_q;
   assign link.ws_host = ws_q;
   assign link.ws_host_oe_n = oe_n_q;

   // resolved pins, own ones included, through two flops each so that
   // clock, word clock and data keep the same delay
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         bclk_s1_q <= 1'b0;
         bclk_s2_q <= 1'b0;
         bclk_s3_q <= 1'b0;
         ws_s1_q <= 1'b0;
         ws_s2_q <= 1'b0;
         sd_s1_q <= 1'b0;
         sd_s2_q <= 1'b0;
      end
      else if (ce_i)
      begin
         bclk_s1_q <= link.link_bclk;
         bclk_s2_q <= bclk_s1_q;
         bclk_s3_q <= bclk_s2_q;
         ws_s1_q <= link.word_select_clock;
         ws_s2_q <= ws_s1_q;
         sd_s1_q <= link.serial_data_out;
         sd_s2_q <= sd_s1_q;
      end
   end

   // master clocks use a supported ratio: 64 or 256 bits a frame
   always_comb
   begin
      tdm = fmt_i == ASP_FMT_TDM;
      div_d = '0;
      bclk_d = 1'b0;
      pos_d = pos_q;
      ws_d = ws_q;
      if (master_i)
      begin
         div_d = (div_q == ASP_HOST_BCLK_CYC - 8'h01) ? 8'h00 : div_q + 8'h01;
         // level from the present count: no short first pulse
         bclk_d = div_q < ASP_HOST_BCLK_HIGH;
         // word clock moves on the fall, clear of the rise
         if (div_q == ASP_HOST_BCLK_HIGH)
         begin
            pos_d = (pos_q == asp_frame_last(fmt_i)) ? 8'h00 : pos_q + 8'h01;
            ws_d = asp_ws_level(fmt_i, pos_d);
         end
      end
   end

   // deserialiser: sample data on the rises that carry the 24 sample bits of a slot
   always_comb
   begin
      rise = bclk_s2_q & ~bclk_s3_q;
      left = (fmt_i == ASP_FMT_I2S) ? ~ws_s2_q : ws_s2_q;
      start = tdm ? (ws_s2_q & ~ws_prev_q) : (ws_s2_q != ws_prev_q);
      ws_prev_d = ws_prev_q;
      bit_d = bit_q;
      slot_d = slot_q;
      shreg_d = shreg_q;
      sample_d = sample_o;
      chan_d = chan_o;
      valid_d = 1'b0;
      didx = '0;
      if (rise)
      begin
         ws_prev_d = ws_s2_q;
         if (start)
         begin
            bit_d = '0;
            slot_d = tdm ? 2'h0 : {1'b0, ~left};
         end
         else if (bit_q == (tdm ? ASP_SLOT_LAST_TDM : ASP_SLOT_LAST_2CH))
         begin
            bit_d = '0;
            slot_d = tdm ? slot_q + 2'h1 : {1'b0, ~slot_q[0]};
         end
         else
         begin
            bit_d = bit_q + 6'h01;
         end
         didx = (fmt_i == ASP_FMT_I2S) ? bit_d - 6'h01 : bit_d;
         // 24 bits MSB first at the head of each slot
         if (didx < ASP_BITS_PER_SAMPLE)
         begin
            shreg_d = {shreg_q[ASP_SAMPLE_W-2:0], sd_s2_q};
         end
         if (didx == ASP_LSB_BIT)
         begin
            sample_d = shreg_d;
            chan_d = slot_d;
            valid_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         div_q <= '0;
         pos_q <= ASP_FRAME_LAST_TDM;
         bclk_q <= 1'b0;
         ws_q <= 1'b0;
         oe_n_q <= 1'b1;
         ws_prev_q <= 1'b0;
         bit_q <= ASP_SLOT_LAST_TDM;
         slot_q <= '0;
         shreg_q <= '0;
         sample_o <= '0;
         chan_o <= '0;
         sample_valid_o <= 1'b0;
      end
      else if (ce_i)
      begin
         div_q <= div_d;
         pos_q <= pos_d;
         bclk_q <= bclk_d;
         ws_q <= ws_d;
         oe_n_q <= ~master_i;
         ws_prev_q <= ws_prev_d;
         bit_q <= bit_d;
         slot_q <= slot_d;
         shreg_q <= shreg_d;
         sample_o <= sample_d;
         chan_o <= chan_d;
         sample_valid_o <= valid_d;
      end
   end
endmodule

// ### dv/asp_link_assertions.sv
// checker for the link that joins the converter end and the receiver end
// assumes one 40 MHz clock; config changes only while reset is held
`timescale 1ns/100ps
module asp_link_assertions (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic bclk_dev_oe_n,
   input wire logic bclk_host_oe_n,
   input wire logic link_bclk,
   input wire logic word_select_clock,
   input wire logic serial_data_out
);
   logic bclk_q, ws_q, seen_q, fseen_q, rise, fall, ws_rise, ws_fall;
   logic [7:0] per_q, hi_q, sync_q;
   logic [8:0] bits_q;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // edge marks of the two link clocks
   assign rise = link_bclk & ~bclk_q;
   assign fall = ~link_bclk & bclk_q;
   assign ws_rise = word_select_clock & ~ws_q;
   assign ws_fall = ~word_select_clock & ws_q;

   // period, high time and frame counters; first frame is not judged
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         {bclk_q, ws_q, seen_q, fseen_q} <= 4'h0;
         {per_q, hi_q, sync_q} <= 24'h0;
         bits_q <= 9'h000;
      end
      else
      begin
         bclk_q <= link_bclk;
         ws_q <= word_select_clock;
         seen_q <= seen_q | rise;
         fseen_q <= fseen_q | ws_rise;
         per_q <= rise ? 8'h01 : per_q + 8'h01;
         hi_q <= link_bclk ? hi_q + 8'h01 : 8'h00;
         sync_q <= ws_rise ? 8'h00 : sync_q + 8'(rise & word_select_clock);
         bits_q <= ws_rise ? 9'h000 : bits_q + 9'(rise);
      end
   end

   // both lines must sit still across the sampling rise
   sequence ws_calm;
      $stable(word_select_clock) ##1 $stable(word_select_clock);
   endsequence
   sequence data_calm;
      $stable(serial_data_out) ##1 $stable(serial_data_out);
   endsequence

   one_driver_a:
      assert property (!(!bclk_dev_oe_n && !bclk_host_oe_n))
      else $error("both ends drive the bit clock");
   bclk_period_a:
      assert property (rise && seen_q |-> per_q inside {8'd12, 8'd16, 8'd24})
      else $error("bit clock period off");
   bclk_high_a:
      assert property (fall |-> hi_q inside {8'd4, 8'd5, 8'd6, 8'd8, 8'd12})
      else $error("bit clock high time off");
   bclk_alive_a:
      assert property (!bclk_dev_oe_n || !bclk_host_oe_n |-> per_q <= 8'd24)
      else $error("bit clock stalled");
   frame_len_a:
      assert property (ws_rise && fseen_q |-> bits_q inside {9'd64, 9'd256})
      else $error("frame length off");
   sync_width_a:
      assert property (ws_fall |-> sync_q inside {8'd32, 8'd128})
      else $error("word clock high width off");
   ws_stable_a:
      assert property ($rose(link_bclk) |-> ws_calm)
      else $error("word clock moved at bit clock rise");
   data_stable_a:
      assert property ($rose(link_bclk) |-> data_calm)
      else $error("data moved at bit clock rise");
   ws_low_change_a:
      assert property ($changed(word_select_clock) |-> !link_bclk)
      else $error("word clock changed while bit clock high");
   data_low_change_a:
      assert property ($changed(serial_data_out) |-> !link_bclk)
      else $error("data changed while bit clock high");
endmodule

// ### dv/tb_top.sv
// bench: converter end and receiver end on one link, plus a slave
// converter end on a second link clocked by the bench at 200 ns
`timescale 1ns/100ps
module tb_top
   import asp_pkg::*;
;
   logic clk_i, rst_i, ce, dev_master, host_master, duty, go;
   logic s_valid, s_ready, s2_valid, s2_ready, underrun, h_valid;
   logic [ASP_SAMPLE_W-1:0] s_data, s2_data, h_sample;
   logic [1:0] h_chan;
   asp_fmt_e fmt;
   asp_speed_e spd;
   int fails, comparisons, cycles;
   asp_if lk();
   asp_if lk2();

   asp_dev asp_dev_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
      .master_i(dev_master), .fmt_i(fmt), .speed_i(spd),
      .divider_duty_select_i(duty), .sample_valid_i(s_valid),
      .sample_data_i(s_data), .sample_ready_o(s_ready),
      .underrun_o(underrun), .link(lk.dev));
   asp_host asp_host_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
      .master_i(host_master), .fmt_i(fmt), .sample_o(h_sample),
      .chan_o(h_chan), .sample_valid_o(h_valid), .link(lk.host));
   asp_dev slave_asp_dev_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
      .master_i(1'b0), .fmt_i(ASP_FMT_TDM), .speed_i(spd),
      .divider_duty_select_i(duty), .sample_valid_i(s2_valid),
      .sample_data_i(s2_data), .sample_ready_o(s2_ready),
      .underrun_o(), .link(lk2.dev));
   asp_link_assertions asp_link_assertions_i (.clk_i(clk_i),
      .rst_i(rst_i), .bclk_dev_oe_n(lk.bclk_dev_oe_n),
      .bclk_host_oe_n(lk.bclk_host_oe_n), .link_bclk(lk.link_bclk),
      .word_select_clock(lk.word_select_clock),
      .serial_data_out(lk.serial_data_out));

   // system clock, 25 ns period
   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // run needs about 69000 cycles; cut a hang short
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 95000)
      begin
         fails++;
         stop_test();
      end
   end

   function automatic logic [23:0] word(input int k);
      return 24'(24'h9c3a51 ^ (24'h111111 * k));
   endfunction

   task automatic chk(input string what, input logic [63:0] exp,
      input logic [63:0] got);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic stop_test();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // config only moves while reset is held
   task automatic do_reset(input logic dm, input asp_fmt_e f,
      input asp_speed_e sp, input logic d);
      rst_i = 1'b1;
      dev_master = dm;
      host_master = !dm;
      fmt = f;
      spd = sp;
      duty = d;
      repeat (16) @(negedge clk_i);
      rst_i = 1'b0;
   endtask

   task automatic wait_underrun();
      int n;
      for (n = 0; n < 2000 && underrun !== 1'b1; n++)
         @(negedge clk_i);
      chk("underrun", 64'h1, 64'(underrun));
      @(negedge clk_i);
   endtask

   // ready seen at a fall stands until the rise that takes the word,
   // so valid and data move only after that rise
   task automatic push(input logic [23:0] w);
      int n;
      s_data = w;
      s_valid = 1'b1;
      for (n = 0; n < 100 && s_ready !== 1'b1; n++)
         @(negedge clk_i);
      @(negedge clk_i);
   endtask

   task automatic run_case(input string name, input logic dm,
      input asp_fmt_e f, input asp_speed_e sp, input logic d, input int per);
      int n, k, c0, nch, hi, lo, fb, hw, ph;
      logic pb, pw;
      nch = (f == ASP_FMT_TDM) ? 4 : 2;
      do_reset(dm, f, sp, d);
      // a slave end needs a frame of sync before words are placed
      repeat (dm ? 1 : 6) wait_underrun();
      for (k = 0; k < 8; k++)
         push(word(k));
      s_valid = 1'b0;
      repeat (2) @(negedge clk_i);
      chk("ready when full", 64'h0, 64'(s_ready));
      // drain; the first slot after reset went out empty
      for (k = 0; k < 8; k++)
      begin
         for (n = 0; n < 2000 && (h_valid !== 1'b1 || h_sample === '0); n++)
            @(negedge clk_i);
         // first word follows one empty slot as master, six as slave
         c0 = (k == 0) ? (dm ? 1 : 6 % nch) : c0;
         chk("sample", 64'(word(k)), 64'(h_sample));
         chk("channel", 64'((c0 + k) % nch), 64'(h_chan));
         @(negedge clk_i);
      end
      wait_underrun();
      // one bit clock period from rise to rise
      {hi, lo, ph} = {32'd0, 32'd0, 32'd0};
      for (n = 0; n < 100 && ph < 4; n++)
      begin
         @(negedge clk_i);
         if (ph == 0 && lk.link_bclk === 1'b0)
            ph = 1;
         else if (ph == 1 && lk.link_bclk === 1'b1)
            ph = 2;
         if (ph == 2 && lk.link_bclk === 1'b0)
            ph = 3;
         else if (ph == 3 && lk.link_bclk === 1'b1)
            ph = 4;
         hi += (ph == 2);
         lo += (ph == 3);
      end
      // rises per frame and rises with the word clock high
      {fb, hw, ph} = {32'd0, 32'd0, 32'd0};
      {pb, pw} = 2'b11;
      for (n = 0; n < 10000 && ph < 2; n++)
      begin
         @(negedge clk_i);
         if (lk.word_select_clock === 1'b1 && pw === 1'b0)
            ph++;
         else if (ph == 1 && lk.link_bclk === 1'b1 && pb === 1'b0)
         begin
            fb++;
            hw += (lk.word_select_clock === 1'b1);
         end
         pb = lk.link_bclk;
         pw = lk.word_select_clock;
      end
      chk("bclk period", 64'(per), 64'(hi + lo));
      chk("bclk high", 64'(d ? per / 3 : per / 2), 64'(hi));
      chk("frame bits", 64'(nch == 4 ? 256 : 64), 64'(fb));
      chk("sync width", 64'(nch == 4 ? 128 : 32), 64'(hw));
      $display("test %s finished", name);
   endtask

   // bench clock of 8 cycles (5 low, 3 high), one-bit frame sync
   task automatic test_bench_slave();
      logic [255:0] cap;
      int fr, b, k;
      do_reset(1'b1, ASP_FMT_LJ, ASP_SPD_SINGLE, 1'b0);
      fork
         for (fr = 0; fr < 3; fr++)
            for (b = 0; b < 256; b++)
            begin
               lk2.bclk_host = 1'b0;
               lk2.ws_host = (b == 0);
               repeat (5) @(negedge clk_i);
               lk2.bclk_host = 1'b1;
               cap = {cap[254:0], lk2.serial_data_out};
               go = go | (fr == 1 && b == 250);
               repeat (3) @(negedge clk_i);
            end
         // words land just before the last frame starts
         begin
            wait (go === 1'b1);
            for (k = 0; k < 4; k++)
            begin
               s2_data = word(k + 8);
               s2_valid = 1'b1;
               while (s2_ready !== 1'b1)
                  @(negedge clk_i);
               @(negedge clk_i);
            end
            s2_valid = 1'b0;
         end
      join
      lk2.bclk_host = 1'b0;
      for (k = 0; k < 4; k++)
         chk("slot", {word(k + 8), 40'h0}, cap[255-64*k -: 64]);
      $display("test bench slave finished");
   endtask

   // main sequence
   initial
   begin
      {rst_i, ce, dev_master, host_master, duty, go} = 6'h30;
      {fmt, spd} = {ASP_FMT_LJ, ASP_SPD_SINGLE};
      {s_valid, s2_valid, s_data, s2_data} = '0;
      {lk2.bclk_host, lk2.bclk_host_oe_n, lk2.ws_host} = 3'h0;
      lk2.ws_host_oe_n = 1'b0;
      run_case("lj", 1'b1, ASP_FMT_LJ,
         ASP_SPD_SINGLE, 1'b0, 24);
      run_case("i2s", 1'b1, ASP_FMT_I2S,
         ASP_SPD_DOUBLE, 1'b1, 16);
      run_case("lj3", 1'b1, ASP_FMT_LJ, ASP_SPD_QUAD, 1'b1, 12);
      run_case("tdm", 1'b1, ASP_FMT_TDM,
         ASP_SPD_DOUBLE, 1'b0, 12);
      run_case("tdms", 1'b0, ASP_FMT_TDM,
         ASP_SPD_SINGLE, 1'b0, 16);
      // two-channel slave on the receiver's own 64-bit frame
      run_case("ljs", 1'b0, ASP_FMT_LJ,
         ASP_SPD_SINGLE, 1'b0, 16);
      test_bench_slave();
      stop_test();
   end
endmodule
